// ---- hw/pmca_pkg.sv ----
// Shared constants, register map and types of the macrocell array
package pmca_pkg;
   localparam int NUM_CELLS      = 8;
   localparam int TERMS_PER_CELL = 9;
   localparam int NUM_TERMS      = 74;
   localparam int PRESET_TERM    = 72;
   localparam int CLEAR_TERM     = 73;
   localparam int NUM_DED_IN     = 8;
   localparam int NUM_ARRAY_IN   = 18;
   localparam int FUSE_W         = 36;
   localparam int FUSE_LO_W      = 32;
   localparam int FUSE_HI_W      = 4;

   // Bus geometry
   localparam int ADDR_W        = 12;
   localparam int DATA_W        = 32;
   localparam int NUM_LANES     = 4;
   localparam int TERM_IDX_W    = 7;
   localparam int TERM_IDX_LSB  = 3;
   localparam int TERM_HI_BIT   = 2;

   // Register offsets (byte addresses)
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] TERM_BASE  = 12'h400;
   localparam logic [11:0] TERM_END   = 12'h650;

   // Control register fields; a stored 1 is an unprogrammed cell
   localparam int ARCH_A_POS = 0;
   localparam int ARCH_B_POS = 8;
   localparam int POL_POS    = 16;
   localparam int CFG_POS    = 24;
   localparam int SEC_POS    = 25;
   localparam logic [31:0] CTRL_RESET = 32'h03FF_FFFF;
   localparam logic [31:0] CTRL_MASK  = 32'h03FF_FFFF;
   localparam logic [31:0] SEC_MASK   = 32'h0000_0001 << SEC_POS;

   // Status register fields
   localparam int ST_Q_POS   = 0;
   localparam int ST_DRV_POS = 8;
   localparam int ST_OE_POS  = 16;

   // Every fuse conductive after erase
   localparam logic [35:0] FUSE_RESET = 36'hF_FFFF_FFFF;
   // Literal columns of the two shared pins (true and complement)
   localparam logic [35:0] SHARED_COLS = 36'h0_000C_0003;

   typedef enum logic [1:0] {
      MODE_REG,
      MODE_BIDIR,
      MODE_IN,
      MODE_OUT
   } pmca_mode_t;
endpackage

// ---- hw/pmca_output_cell.sv ----
// One output macro cell: mode decode, polarity, register and pin driver
`timescale 1ns/100ps
module pmca_output_cell
   import pmca_pkg::*;
(
   input  logic                      ref_clk_in,
   input  logic                      rst_in,
   input  logic                      ce_in,
   input  logic [TERMS_PER_CELL-1:0] terms_in,
   input  logic                      arch_a_in,
   input  logic                      arch_b_in,
   input  logic                      polarity_in,
   input  logic                      cfg_prog_in,
   input  logic                      clk_edge_in,
   input  logic                      preset_in,
   input  logic                      clear_in,
   input  logic                      enable_pin_in,
   input  logic                      pin_level_in,
   output logic                      pin_out,
   output logic                      pin_oe_out,
   output logic                      feedback_out,
   output logic                      reg_q_out
);
   pmca_mode_t mode;
   logic       q_q;
   logic       q_d;
   logic       drv_q;
   logic       drv_d;
   logic       oe_q;
   logic       oe_d;

   wire dir_term = terms_in[0];
   wire sum      = |terms_in[TERMS_PER_CELL-1:1];
   // Unprogrammed polarity inverts, programmed passes straight
   wire value    = polarity_in ? ~sum : sum;
   // Registers only clock when the shared pin is a clock
   wire reg_clk  = clk_edge_in & cfg_prog_in;

   assign mode = (!arch_a_in && !arch_b_in) ? MODE_REG :
                 (arch_a_in && arch_b_in)   ? MODE_BIDIR :
                 arch_a_in                  ? MODE_IN : MODE_OUT;

   // Clear wins over preset and clock
   assign q_d = clear_in ? 1'b0 :
                (mode == MODE_REG && reg_clk) ? (preset_in | value) : q_q;

   always_comb begin
      drv_d        = value;
      oe_d         = 1'b0;
      feedback_out = 1'b0;
      unique case (mode)
         MODE_REG: begin
            drv_d        = q_d;
            oe_d         = cfg_prog_in & ~enable_pin_in;
            feedback_out = q_q;
         end
         MODE_BIDIR: begin
            oe_d         = dir_term;
            feedback_out = pin_level_in;
         end
         MODE_IN: begin
            oe_d         = 1'b0;
            feedback_out = pin_level_in;
         end
         MODE_OUT: begin
            oe_d         = 1'b1;
            feedback_out = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_q   <= 1'b0;
         drv_q <= 1'b0;
         oe_q  <= 1'b0;
      end else if (ce_in) begin
         q_q   <= q_d;
         drv_q <= drv_d;
         oe_q  <= oe_d;
      end
   end

   assign pin_out    = drv_q;
   assign pin_oe_out = oe_q;
   assign reg_q_out  = q_q;

   chk_bidir_dir: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && mode == MODE_BIDIR) |=> pin_oe_out == $past(dir_term))
      else $error("bidirectional enable not from direction term");
   chk_reg_enable: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && mode == MODE_REG) |=> pin_oe_out == $past(cfg_prog_in & ~enable_pin_in))
      else $error("registered enable not from shared pin");
   chk_input_float: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && mode == MODE_IN) |=> !pin_oe_out)
      else $error("fixed input cell drives its pin");
   chk_clear_regs: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && clear_in) |=> (!reg_q_out && (mode != MODE_REG || !pin_out)))
      else $error("clear term did not clear register");
   chk_preset_reg: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && !clear_in && preset_in && reg_clk && mode == MODE_REG) |=> reg_q_out)
      else $error("preset term did not set register");
   chk_out_polarity: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && mode == MODE_OUT) |=> pin_out == ($past(polarity_in) ^ $past(sum)))
      else $error("output polarity wrong");
   chk_out_nofeed: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (mode == MODE_OUT) |-> !feedback_out)
      else $error("fixed output cell feeds back");
   chk_reg_hold: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && !clear_in && !reg_clk) |=> $stable(reg_q_out))
      else $error("register changed without clock edge");
endmodule

// ---- hw/pmca_macrocell_array.sv ----
// Macrocell array top: fuse store, AND array, bus slave and eight output cells
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Function
// - Eight cells get nine terms each; eight terms OR into the cell logic.
// - First term of each cell is the direction control of its pin driver.
// - Two shared terms: synchronous preset at clock edge, immediate clear.
// - Each cell has its own pair of architecture bits, sixteen in all.
// - Each cell has a polarity bit choosing inversion before the pin.
// - Architecture bits decode to registered, bidirectional, fixed input, fixed output.
// - Programmed shared cell: pins are clock and enable; else plain inputs.
// - Registered cells are enabled only from the shared enable pin.
// - Bidirectional cells are enabled only from their direction term.
// - Shared cell low selects clock and enable, high selects inputs.
// - Both bits programmed: register on shared clock, enable from shared pin.
// - Both bits unprogrammed: pin feeds array, driver by direction term.
// - First bit programmed only: fixed output, no feedback; reverse: fixed input.
// - Erased state: terms zero, inverting, shared pins inputs, drivers off.
// - Programmed security fuse blocks any readback of the pattern.
// - All registers clear at power-up before any clock edge.
module pmca_macrocell_array
   import pmca_pkg::*;
(
   input  logic                  ref_clk_in,
   input  logic                  rst_in,
   input  logic                  ce_in,
   input  logic [ADDR_W-1:0]     avs_address_in,
   input  logic                  avs_read_in,
   input  logic                  avs_write_in,
   input  logic [DATA_W-1:0]     avs_writedata_in,
   input  logic [NUM_LANES-1:0]  avs_byteenable_in,
   output logic [DATA_W-1:0]     avs_readdata_out,
   output logic                  avs_waitrequest_out,
   input  logic                  shared_clock_pin_in,
   input  logic [NUM_DED_IN-1:0] dedicated_pin_in,
   input  logic                  shared_enable_pin_in,
   input  logic [NUM_CELLS-1:0]  macro_pin_in,
   output logic [NUM_CELLS-1:0]  macro_pin_out,
   output logic [NUM_CELLS-1:0]  macro_pin_oe_out
);
   logic                  ack_q;
   logic [DATA_W-1:0]     rd_q;
   logic [DATA_W-1:0]     ctrl_q;
   logic [FUSE_W-1:0]     fuse_q [NUM_TERMS];
   logic                  clk_q;
   logic                  oe_q;
   logic [NUM_DED_IN-1:0] ded_q;
   logic [NUM_CELLS-1:0]  pin_in_q;
   logic [NUM_CELLS-1:0]  cell_fb;
   logic [NUM_CELLS-1:0]  cell_q;
   logic [DATA_W-1:0]     ctrl_merge;
   logic [FUSE_LO_W-1:0]  lo_merge;
   logic [DATA_W-1:0]     status_word;
   logic [2*NUM_ARRAY_IN-1:0] lit;
   logic [NUM_TERMS-1:0]  term;

   // Bus decode; one wait cycle, then the transfer completes
   wire bus_req  = avs_read_in | avs_write_in;
   wire wr_take  = avs_write_in & ack_q;
   wire rd_load  = avs_read_in & ~ack_q;
   wire [ADDR_W-1:0] word_addr  = {avs_address_in[ADDR_W-1:2], 2'b00};
   wire ctrl_hit   = word_addr == CTRL_OFS;
   wire status_hit = word_addr == STATUS_OFS;
   wire term_hit   = (word_addr >= TERM_BASE) && (word_addr < TERM_END);
   wire [ADDR_W-1:0] term_off   = word_addr - TERM_BASE;
   wire [TERM_IDX_W-1:0] term_idx = term_off[TERM_IDX_LSB +: TERM_IDX_W];
   wire term_hi    = term_off[TERM_HI_BIT];
   wire [TERM_IDX_W-1:0] term_sel = term_hit ? term_idx : '0;
   wire [FUSE_W-1:0] term_word = fuse_q[term_sel];

   wire secured  = ~ctrl_q[SEC_POS];
   wire cfg_prog = ~ctrl_q[CFG_POS];

   assign avs_waitrequest_out = bus_req & ~ack_q;

   // Byte-lane merge for control and low fuse words
   for (genvar b = 0; b < NUM_LANES; b++) begin : g_lane
      assign ctrl_merge[8*b +: 8] = avs_byteenable_in[b] ?
                                    avs_writedata_in[8*b +: 8] : ctrl_q[8*b +: 8];
      assign lo_merge[8*b +: 8]   = avs_byteenable_in[b] ?
                                    avs_writedata_in[8*b +: 8] : term_word[8*b +: 8];
   end

   wire [FUSE_HI_W-1:0] hi_merge = avs_byteenable_in[0] ?
                                   avs_writedata_in[FUSE_HI_W-1:0] :
                                   term_word[FUSE_W-1:FUSE_LO_W];
   wire [FUSE_W-1:0] term_merge = term_hi ?
                                  {hi_merge, term_word[FUSE_LO_W-1:0]} :
                                  {term_word[FUSE_W-1:FUSE_LO_W], lo_merge};
   // Security fuse can be programmed but only erased by reset
   wire [DATA_W-1:0] ctrl_next = ctrl_merge & CTRL_MASK & (ctrl_q | ~SEC_MASK);

   always_comb begin
      status_word = '0;
      status_word[ST_Q_POS +: NUM_CELLS]   = cell_q;
      status_word[ST_DRV_POS +: NUM_CELLS] = macro_pin_out;
      status_word[ST_OE_POS +: NUM_CELLS]  = macro_pin_oe_out;
   end

   // Pattern readback hidden once secured
   wire [DATA_W-1:0] term_rd = secured ? '0 :
                               term_hi ? {28'h000_0000, term_word[FUSE_W-1:FUSE_LO_W]} :
                               term_word[FUSE_LO_W-1:0];
   wire [DATA_W-1:0] ctrl_rd = secured ? '0 : ctrl_q;
   wire [DATA_W-1:0] rd_data = ctrl_hit   ? ctrl_rd :
                               status_hit ? status_word :
                               term_hit   ? term_rd : '0;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_q <= 1'b0;
         rd_q  <= '0;
      end else if (ce_in) begin
         ack_q <= bus_req & ~ack_q;
         if (rd_load) begin
            rd_q <= rd_data;
         end
      end
   end

   assign avs_readdata_out = rd_q;

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= CTRL_RESET;
      end else if (ce_in && wr_take && ctrl_hit) begin
         ctrl_q <= ctrl_next;
      end
   end

   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         for (int k = 0; k < NUM_TERMS; k++) begin
            fuse_q[k] <= FUSE_RESET;
         end
      end else if (ce_in && wr_take && term_hit) begin
         fuse_q[term_sel] <= term_merge;
      end
   end

   // Pins are sampled so the array never forms a loop through the board
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         clk_q    <= 1'b0;
         oe_q     <= 1'b0;
         ded_q    <= '0;
         pin_in_q <= '0;
      end else if (ce_in) begin
         clk_q    <= shared_clock_pin_in;
         oe_q     <= shared_enable_pin_in;
         ded_q    <= dedicated_pin_in;
         pin_in_q <= macro_pin_in;
      end
   end

   wire [NUM_ARRAY_IN-1:0] array_in = {cell_fb, oe_q, ded_q, clk_q};
   // Shared pins drop out of the array while they are clock and enable
   wire [2*NUM_ARRAY_IN-1:0] ignore_cols = cfg_prog ? SHARED_COLS : '0;
   wire clk_edge = cfg_prog & shared_clock_pin_in & ~clk_q;

   for (genvar i = 0; i < NUM_ARRAY_IN; i++) begin : g_lit
      assign lit[2*i]   = array_in[i];
      assign lit[2*i+1] = ~array_in[i];
   end

   // A conductive fuse keeps its literal; erased terms see x and not x
   for (genvar k = 0; k < NUM_TERMS; k++) begin : g_term
      assign term[k] = &(~fuse_q[k] | lit | ignore_cols);
      chk_virgin_term: assert property (@(posedge ref_clk_in) disable iff (rst_in)
         (fuse_q[k] == FUSE_RESET) |-> !term[k])
         else $error("erased product term not low");
   end

   for (genvar n = 0; n < NUM_CELLS; n++) begin : g_cell
      pmca_output_cell u_cell (
         .ref_clk_in    (ref_clk_in),
         .rst_in        (rst_in),
         .ce_in         (ce_in),
         .terms_in      (term[n*TERMS_PER_CELL +: TERMS_PER_CELL]),
         .arch_a_in     (ctrl_q[ARCH_A_POS+n]),
         .arch_b_in     (ctrl_q[ARCH_B_POS+n]),
         .polarity_in   (ctrl_q[POL_POS+n]),
         .cfg_prog_in   (cfg_prog),
         .clk_edge_in   (clk_edge),
         .preset_in     (term[PRESET_TERM]),
         .clear_in      (term[CLEAR_TERM]),
         .enable_pin_in (oe_q),
         .pin_level_in  (pin_in_q[n]),
         .pin_out       (macro_pin_out[n]),
         .pin_oe_out    (macro_pin_oe_out[n]),
         .feedback_out  (cell_fb[n]),
         .reg_q_out     (cell_q[n])
      );
   end

   chk_secure_sticky: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      secured |=> secured)
      else $error("security fuse was erased by software");
   chk_secure_read: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (avs_read_in && !avs_waitrequest_out && secured && (term_hit || ctrl_hit))
      |-> avs_readdata_out == '0)
      else $error("pattern read back while secured");
   chk_bus_answer: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && avs_waitrequest_out) |=> (!avs_waitrequest_out || !bus_req))
      else $error("bus answer later than one wait cycle");
   chk_shared_inputs: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (!cfg_prog && ce_in) |=> $stable(cell_q) || $past(term[CLEAR_TERM]))
      else $error("register clocked with shared pins as inputs");
   chk_status_view: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      (ce_in && rd_load && status_hit) |=> rd_q[ST_Q_POS +: NUM_CELLS] == $past(cell_q))
      else $error("status read does not show register state");
endmodule

// ---- test/pmca_board_model.sv ----
// Board model: drives and resolves the eight cell pins
`timescale 1ns/100ps
module pmca_board_model (
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] pin_drv_in,
   input  wire logic [7:0] pin_oe_in,
   input  wire logic [7:0] board_val_in,
   input  wire logic [7:0] board_en_in,
   output      logic [7:0] pin_level_out
);
   logic [7:0] float_q = 8'h5A;

   // An undriven pin toggles every cycle so a stale level never looks valid
   always @(posedge ref_clk_in) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe_in[i])
            pin_level_out[i] = pin_drv_in[i];
         else if (board_en_in[i])
            pin_level_out[i] = board_val_in[i];
         else
            pin_level_out[i] = float_q[i];
      end
   end
endmodule

// ---- test/pmca_testbench.sv ----
// Self-checking bench for the macrocell array
`timescale 1ns/100ps
module testbench;
   import pmca_pkg::*;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic [ADDR_W-1:0]     addr = '0;
   logic                  rd = 1'b0;
   logic                  wr = 1'b0;
   logic [DATA_W-1:0]     wdata = '0;
   logic [DATA_W-1:0]     rdata;
   logic                  wait_req;
   logic                  sclk = 1'b0;
   logic                  sen = 1'b1;
   logic [NUM_DED_IN-1:0] ded = '0;
   logic [NUM_CELLS-1:0]  pin_lvl;
   logic [NUM_CELLS-1:0]  pin_drv;
   logic [NUM_CELLS-1:0]  pin_oe;
   logic [7:0]            bd_val = '0;
   logic [7:0]            bd_en = '0;
   int                    fails = 0;
   int                    n_tests = 0;
   int                    cycles = 0;

   pmca_macrocell_array dut_u (
      .ref_clk_in           (clk),
      .rst_in               (rst),
      .ce_in                (1'b1),
      .avs_address_in       (addr),
      .avs_read_in          (rd),
      .avs_write_in         (wr),
      .avs_writedata_in     (wdata),
      .avs_byteenable_in    (4'hF),
      .avs_readdata_out     (rdata),
      .avs_waitrequest_out  (wait_req),
      .shared_clock_pin_in  (sclk),
      .dedicated_pin_in     (ded),
      .shared_enable_pin_in (sen),
      .macro_pin_in         (pin_lvl),
      .macro_pin_out        (pin_drv),
      .macro_pin_oe_out     (pin_oe)
   );

   pmca_board_model board_u (
      .ref_clk_in    (clk),
      .pin_drv_in    (pin_drv),
      .pin_oe_in     (pin_oe),
      .board_val_in  (bd_val),
      .board_en_in   (bd_en),
      .pin_level_out (pin_lvl)
   );

   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         results();
      end
   end

   task results;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task pchk(input string nm, input logic seen, input logic exp);
      chk(nm, 32'(seen), 32'(exp));
   endtask

   // One Avalon transfer, held until waitrequest is sampled low at a rising edge
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
      int   n;
      logic stall;
      n = 0;
      stall = 1'b1;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= ~w;
      // Waitrequest is settled mid-cycle; the edge after that look is where it counts
      while (stall && n < 100) begin
         @(negedge clk);
         stall = (wait_req !== 1'b0);
         @(posedge clk);
         n++;
      end
      if (n >= 100) begin
         fails++;
         $display("unexpected bus stall at %h", a);
      end
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task wreg(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(1'b0, a, 32'h0000_0000, v);
      chk(nm, v, exp);
   endtask

   task set_term(input int t, input logic [35:0] f);
      wreg(TERM_BASE + 12'(8 * t), f[31:0]);
      wreg(TERM_BASE + 12'(8 * t + 4), {28'h000_0000, f[35:32]});
   endtask

   // Inputs are sampled at one edge and reach the pins at the next
   task settle;
      repeat (3) @(posedge clk);
   endtask

   task clk_pulse;
      @(posedge clk);
      sclk <= 1'b1;
      settle();
      @(posedge clk);
      sclk <= 1'b0;
      settle();
   endtask

   task t_reset;
      rchk("ctrl reset", CTRL_OFS, 32'h03FF_FFFF);
      rchk("status reset", STATUS_OFS, 32'h0000_FF00);
      rchk("unmapped", 12'h0F0, 32'h0000_0000);
      rchk("erased term", TERM_BASE, 32'hFFFF_FFFF);
      @(posedge clk);
      ded <= 8'hFF;
      settle();
      chk("erased oe", 32'(pin_oe), 32'h0000_0000);
      $display("reset test done");
   endtask

   task t_comb;
      set_term(0, 36'h0_0000_0000);
      set_term(1, 36'h0_0000_0004);
      set_term(2, 36'h0_0000_0400);
      set_term(10, 36'h0_0000_0004);
      wreg(CTRL_OFS, 32'h03FF_FBFD);
      @(posedge clk);
      ded <= 8'h01;
      settle();
      chk("mode oe", 32'(pin_oe), 32'h0000_0003);
      chk("inverted", 32'(pin_drv[1:0]), 32'h0000_0000);
      @(posedge clk);
      ded <= 8'h00;
      settle();
      chk("inverted low", 32'(pin_drv[1:0]), 32'h0000_0003);
      wreg(CTRL_OFS, 32'h03FE_FBFD);
      settle();
      pchk("pass low", pin_drv[0], 1'h0);
      @(posedge clk);
      ded <= 8'h10;
      settle();
      pchk("second term", pin_drv[0], 1'h1);
      @(posedge clk);
      ded <= 8'h00;
      bd_en <= 8'h04;
      bd_val <= 8'h04;
      set_term(4, 36'h0_0100_0000);
      settle();
      pchk("input feedback", pin_drv[0], 1'h1);
      @(posedge clk);
      bd_val <= 8'h00;
      settle();
      pchk("input feedback low", pin_drv[0], 1'h0);
      set_term(3, 36'h0_0080_0000);
      settle();
      pchk("output no feedback", pin_drv[0], 1'h1);
      $display("combinational test done");
   endtask

   task t_reg;
      set_term(28, 36'h0_0000_0010);
      set_term(73, 36'h0_0000_0040);
      set_term(72, 36'h0_0000_0100);
      wreg(CTRL_OFS, 32'h02F6_F3F5);
      @(posedge clk);
      sen <= 1'b0;
      ded <= 8'h02;
      settle();
      pchk("no edge yet", pin_drv[3], 1'h0);
      pchk("shared oe on", pin_oe[3], 1'h1);
      clk_pulse();
      pchk("registered", pin_drv[3], 1'h1);
      @(posedge clk);
      sen <= 1'b1;
      settle();
      pchk("shared oe off", pin_oe[3], 1'h0);
      pchk("bidir oe kept", pin_oe[0], 1'h1);
      @(posedge clk);
      ded <= 8'h06;
      settle();
      pchk("clear", pin_drv[3], 1'h0);
      @(posedge clk);
      ded <= 8'h08;
      settle();
      pchk("preset waits", pin_drv[3], 1'h0);
      clk_pulse();
      pchk("preset", pin_drv[3], 1'h1);
      $display("registered test done");
   endtask

   task t_sec;
      rchk("ctrl back", CTRL_OFS, 32'h02F6_F3F5);
      rchk("term back", TERM_BASE + 12'h008, 32'h0000_0004);
      wreg(CTRL_OFS, 32'h00F6_F3F5);
      rchk("ctrl secured", CTRL_OFS, 32'h0000_0000);
      rchk("term secured", TERM_BASE + 12'h008, 32'h0000_0000);
      $display("security test done");
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_comb();
      t_reg();
      t_sec();
      results();
   end
endmodule
